//--- rtl/sdcc_ctrl.sv
// Converter control: AHB-Lite registers, DAC code shadow, result capture, clocks.
// Assumes the SINC filter delivers a 24-bit word with a one-cycle done pulse.
//
// Behaviour
// - Positive select code routes input per table.
// - Twelve-bit DAC code over two bytes, reset zero.
// - Low DAC byte shadowed until high written.
// - DAC control bit 7 enables DAC.
// - DAC reference: regulator, supply or common mode.
// - Unimplemented bits ignore writes, read zero.
// - Result 24 bits, three read-only bytes.
// - Soft reset holds filter, blocks conversions.
// - Sleep powers down all but PGA, bandgap.
// - Power-off resets high, overrides sleep, reset.
// - Oversample code sets ratio 16384 down to 128.
// - Bit 0 picks internal or external references.
// - Filter mode sets sample_double_factor and divide.
// - Sample_double_factor two doubles samples, one low latency.
// - Buffer bits enable buffers, zero bypasses.
// - Latch holds results, suppresses flag, interrupt.
// - End flag set by hardware, cleared by firmware.
// - Clock select divides system clock or passes.
// - Data rate is clock over divider, sample_double_factor, ratio.
// - Conversion end sets flag and interrupt request.
// - Results overwritten each conversion unless latched.
//
// The AHB-Lite slave port and the address map are this design's own decisions.
`default_nettype none
module sdcc_ctrl (
    input  wire logic                  clk,          // System clock
    input  wire logic                  rst_n,        // Synchronous reset, active low
    input  wire logic                  hsel,         // AHB slave select
    input  wire logic [7:0]            haddr,        // AHB address
    input  wire logic [1:0]            htrans,       // AHB transfer type
    input  wire logic                  hwrite,       // AHB write
    input  wire logic [2:0]            hsize,        // AHB size
    input  wire logic [31:0]           hwdata,       // AHB write data
    input  wire logic                  hready,       // AHB bus ready
    output logic [31:0]                hrdata,       // AHB read data
    output logic                       hreadyout,    // AHB slave ready
    output logic                       hresp,        // AHB response
    input  wire logic                  convDone,     // Filter result pulse
    input  wire logic [23:0]           convData,     // Filter result word
    output sdcc_pkg::sdcc_analog_t     analog,       // Analog controls
    output logic                       modClkEn,     // Modulator source clock tick
    output logic                       convIrq       // Interrupt request pulse
);
    // ----------------------------------------
    // Bus address phase capture
    // ----------------------------------------
    logic       wrPend_q;
    logic [7:0] wrAddr_q;
    logic [7:0] posSel_q, dacHigh_q, dacLow_q, dacShadow_q, dacCtrl_q;
    logic [7:0] ctrl0_q, ctrl1_q, clkSel_q;
    logic [23:0] result_q;
    logic [7:0] rdByte;
    logic [4:0] clkCnt_q;
    logic       clkHalf_q;
    logic       addrTake, wrData;
    logic [7:0] wByte;
    logic       powered, running, capture;

    assign addrTake  = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign wrData    = wrPend_q;
    assign wByte     = hwdata[7:0];

    function automatic logic hit(input logic [7:0] a);
        hit = wrData && (wrAddr_q == a);
    endfunction

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 8'h00;
        end
        else
        begin
            wrPend_q <= addrTake && hwrite;
            wrAddr_q <= haddr;
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    logic eocSet;
    assign powered = !ctrl0_q[sdcc_pkg::BIT_POWER_OFF];
    assign running = powered && !ctrl0_q[sdcc_pkg::BIT_SLEEP]
                     && !ctrl0_q[sdcc_pkg::BIT_SOFT_RST];
    assign capture = convDone && running && !ctrl1_q[sdcc_pkg::BIT_LATCH];
    assign eocSet  = capture;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            posSel_q    <= sdcc_pkg::RST_ZERO;
            dacHigh_q   <= sdcc_pkg::RST_ZERO;
            dacLow_q    <= sdcc_pkg::RST_ZERO;
            dacShadow_q <= sdcc_pkg::RST_ZERO;
            dacCtrl_q   <= sdcc_pkg::RST_ZERO;
            ctrl0_q     <= sdcc_pkg::RST_CTRL0;
            ctrl1_q     <= sdcc_pkg::RST_ZERO;
            clkSel_q    <= sdcc_pkg::RST_ZERO;
        end
        else
        begin
            if (hit(sdcc_pkg::ADDR_POS_SEL))
                posSel_q <= wByte & sdcc_pkg::MASK_POS_SEL;
            if (hit(sdcc_pkg::ADDR_DAC_LOW))
                dacShadow_q <= wByte & sdcc_pkg::MASK_DAC_LOW;
            if (hit(sdcc_pkg::ADDR_DAC_HIGH))
            begin
                dacHigh_q <= wByte;
                dacLow_q  <= dacShadow_q;
            end
            if (hit(sdcc_pkg::ADDR_DAC_CTRL))
                dacCtrl_q <= wByte & sdcc_pkg::MASK_DAC_CTRL;
            if (hit(sdcc_pkg::ADDR_CTRL0))
                ctrl0_q <= wByte & sdcc_pkg::MASK_CTRL0;
            if (hit(sdcc_pkg::ADDR_CLK_SEL))
                clkSel_q <= wByte & sdcc_pkg::MASK_CLK_SEL;
            if (hit(sdcc_pkg::ADDR_CTRL1))
                ctrl1_q <= (wByte & sdcc_pkg::MASK_CTRL1)
                           | ({7'h00, wByte[sdcc_pkg::BIT_EOC] | eocSet}
                              << sdcc_pkg::BIT_EOC);
            else if (eocSet)
                ctrl1_q[sdcc_pkg::BIT_EOC] <= 1'b1;
        end
    end

    // ----------------------------------------
    // Result capture
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (capture)
            result_q <= convData;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            convIrq <= 1'b0;
        else
            convIrq <= eocSet;
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always_comb
    begin
        case (haddr)
            sdcc_pkg::ADDR_POS_SEL:  rdByte = posSel_q;
            sdcc_pkg::ADDR_DAC_HIGH: rdByte = dacHigh_q;
            sdcc_pkg::ADDR_DAC_LOW:  rdByte = dacShadow_q;
            sdcc_pkg::ADDR_DAC_CTRL: rdByte = dacCtrl_q;
            sdcc_pkg::ADDR_RES_LOW:  rdByte = result_q[7:0];
            sdcc_pkg::ADDR_RES_MID:  rdByte = result_q[15:8];
            sdcc_pkg::ADDR_RES_HIGH: rdByte = result_q[23:16];
            sdcc_pkg::ADDR_CTRL0:    rdByte = ctrl0_q;
            sdcc_pkg::ADDR_CTRL1:    rdByte = ctrl1_q;
            sdcc_pkg::ADDR_CLK_SEL:  rdByte = clkSel_q;
            default:                 rdByte = 8'h00;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            hrdata <= 32'h0000_0000;
        else if (addrTake && !hwrite)
            hrdata <= {24'h00_0000, rdByte};
    end

    // ----------------------------------------
    // Modulator source clock divider
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            clkCnt_q  <= 5'h00;
            clkHalf_q <= 1'b0;
        end
        else if (!clkHalf_q)
            clkHalf_q <= 1'b1;
        else
        begin
            clkHalf_q <= 1'b0;
            clkCnt_q  <= (clkCnt_q >= clkSel_q[4:0]) ? 5'h00 : clkCnt_q + 5'h01;
        end
    end
    assign modClkEn = (clkSel_q[4:0] == sdcc_pkg::CLK_UNDIVIDED) ? 1'b1
                      : (clkHalf_q && clkCnt_q >= clkSel_q[4:0]);

    // ----------------------------------------
    // Analog control decode
    // ----------------------------------------
    function automatic sdcc_pkg::sdcc_route_t route(input logic [2:0] c);
        case (c)
            3'h0:    route = sdcc_pkg::SDCC_IN_PIN0;
            3'h1:    route = sdcc_pkg::SDCC_IN_PIN2;
            3'h4:    route = sdcc_pkg::SDCC_IN_DACO;
            3'h5:    route = sdcc_pkg::SDCC_IN_GND;
            3'h6:    route = sdcc_pkg::SDCC_IN_CM;
            3'h7:    route = sdcc_pkg::SDCC_IN_TSP;
            default: route = sdcc_pkg::SDCC_IN_RSVD;
        endcase
    endfunction

    logic [2:0] fm;
    assign fm = ctrl1_q[7:5];
    always_comb
    begin
        analog.posRoute    = route(posSel_q[2:0]);
        analog.dacCode     = {dacHigh_q, dacLow_q[3:0]};
        analog.dacEnable   = dacCtrl_q[sdcc_pkg::BIT_DAC_EN];
        analog.dacRef      = dacCtrl_q[6] ? sdcc_pkg::SDCC_DREF_CM
                             : (dacCtrl_q[5] ? sdcc_pkg::SDCC_DREF_VIN
                                            : sdcc_pkg::SDCC_DREF_REG);
        analog.powerDown   = !powered;
        analog.sleep       = powered && ctrl0_q[sdcc_pkg::BIT_SLEEP];
        analog.filterReset = powered && ctrl0_q[sdcc_pkg::BIT_SOFT_RST];
        analog.refExternal = ctrl0_q[sdcc_pkg::BIT_REF_PAIR];
        analog.negBufEn    = ctrl1_q[sdcc_pkg::BIT_NEG_BUF];
        analog.posBufEn    = ctrl1_q[sdcc_pkg::BIT_POS_BUF];
        analog.chopDouble  = !fm[2];
        analog.modDivider  = fm[1] ? sdcc_pkg::DIV_SHORT : sdcc_pkg::DIV_LONG;
        analog.filterValid = !fm[0];
        analog.oversampleRatio = 15'(1) << (sdcc_pkg::OSR_MAX_LOG2
                                 - int'(ctrl0_q[4:2]));
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_latch_hold;
        @(posedge clk) disable iff (!rst_n)
        ctrl1_q[sdcc_pkg::BIT_LATCH] |=> $stable(result_q);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("result moved while latched");

    property p_eoc_set;
        @(posedge clk) disable iff (!rst_n)
        capture |=> ctrl1_q[sdcc_pkg::BIT_EOC] && convIrq;
    endproperty
    a_eoc_set: assert property (p_eoc_set) else $error("end flag not set");

    property p_irq_cause;
        @(posedge clk) disable iff (!rst_n)
        convIrq |-> $past(capture);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without result");

    property p_shadow;
        @(posedge clk) disable iff (!rst_n)
        hit(sdcc_pkg::ADDR_DAC_LOW) && !hit(sdcc_pkg::ADDR_DAC_HIGH)
        |=> $stable(dacLow_q);
    endproperty
    a_shadow: assert property (p_shadow) else $error("low code changed early");

    property p_poweroff;
        @(posedge clk) disable iff (!rst_n)
        ctrl0_q[sdcc_pkg::BIT_POWER_OFF] |-> !analog.sleep && !analog.filterReset;
    endproperty
    a_poweroff: assert property (p_poweroff) else $error("power-off not dominant");

    property p_reset_blocks;
        @(posedge clk) disable iff (!rst_n)
        ctrl0_q[sdcc_pkg::BIT_SOFT_RST] |=> $stable(result_q);
    endproperty
    a_reset_blocks: assert property (p_reset_blocks) else $error("result during reset");

    property p_capture;
        @(posedge clk) disable iff (!rst_n)
        capture |=> result_q == $past(convData);
    endproperty
    a_capture: assert property (p_capture) else $error("result not loaded");

    property p_ctrl_reset;
        @(posedge clk)
        !rst_n |=> ctrl0_q == sdcc_pkg::RST_CTRL0 && dacHigh_q == 8'h00;
    endproperty
    a_ctrl_reset: assert property (p_ctrl_reset) else $error("bad reset value");

    property p_eoc_sticky;
        @(posedge clk) disable iff (!rst_n)
        ctrl1_q[sdcc_pkg::BIT_EOC] && !hit(sdcc_pkg::ADDR_CTRL1) |=> ctrl1_q[sdcc_pkg::BIT_EOC];
    endproperty
    a_eoc_sticky: assert property (p_eoc_sticky) else $error("end flag cleared");

    property p_latch_no_flag;
        @(posedge clk) disable iff (!rst_n)
        ctrl1_q[sdcc_pkg::BIT_LATCH] && !hit(sdcc_pkg::ADDR_CTRL1)
        |=> $stable(ctrl1_q[sdcc_pkg::BIT_EOC]);
    endproperty
    a_latch_no_flag: assert property (p_latch_no_flag) else $error("flag moved while latched");

    property p_latch_no_irq;
        @(posedge clk) disable iff (!rst_n)
        ctrl1_q[sdcc_pkg::BIT_LATCH] |=> !convIrq;
    endproperty
    a_latch_no_irq: assert property (p_latch_no_irq) else $error("irq while latched");

    property p_dac_load;
        @(posedge clk) disable iff (!rst_n)
        hit(sdcc_pkg::ADDR_DAC_HIGH)
        |=> analog.dacCode == {$past(wByte), $past(dacShadow_q[3:0])};
    endproperty
    a_dac_load: assert property (p_dac_load) else $error("shadow not applied");

    property p_dac_reset;
        @(posedge clk)
        !rst_n |=> analog.dacCode == 12'h000 && !analog.dacEnable;
    endproperty
    a_dac_reset: assert property (p_dac_reset) else $error("dac not reset");

    property p_unimpl_zero;
        @(posedge clk) disable iff (!rst_n)
        (dacCtrl_q & ~sdcc_pkg::MASK_DAC_CTRL) == sdcc_pkg::RST_ZERO
        && (clkSel_q & ~sdcc_pkg::MASK_CLK_SEL) == sdcc_pkg::RST_ZERO
        && (dacShadow_q & ~sdcc_pkg::MASK_DAC_LOW) == sdcc_pkg::RST_ZERO
        && ctrl0_q[1] == 1'b0
        && ctrl1_q[0] == 1'b0;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unused bit set");

    property p_read_upper;
        @(posedge clk) disable iff (!rst_n)
        hrdata[31:8] == 24'h00_0000;
    endproperty
    a_read_upper: assert property (p_read_upper) else $error("upper read bits set");

    property p_undivided;
        @(posedge clk) disable iff (!rst_n)
        clkSel_q[4:0] == sdcc_pkg::CLK_UNDIVIDED |-> modClkEn;
    endproperty
    a_undivided: assert property (p_undivided) else $error("undivided clock gap");

    property p_divided_gap;
        @(posedge clk) disable iff (!rst_n)
        modClkEn && clkSel_q[4:0] != sdcc_pkg::CLK_UNDIVIDED && !hit(sdcc_pkg::ADDR_CLK_SEL)
        |=> !modClkEn;
    endproperty
    a_divided_gap: assert property (p_divided_gap) else $error("divided tick too long");

    property p_sleep_gate;
        @(posedge clk) disable iff (!rst_n)
        convDone && analog.sleep |=> $stable(result_q);
    endproperty
    a_sleep_gate: assert property (p_sleep_gate) else $error("result while asleep");

    property p_poweroff_gate;
        @(posedge clk) disable iff (!rst_n)
        convDone && analog.powerDown |=> $stable(result_q) && !convIrq;
    endproperty
    a_poweroff_gate: assert property (p_poweroff_gate) else $error("result while off");

    property p_mode_decode;
        @(posedge clk) disable iff (!rst_n)
        analog.chopDouble == !ctrl1_q[7]
        && analog.modDivider == (ctrl1_q[6] ? sdcc_pkg::DIV_SHORT : sdcc_pkg::DIV_LONG);
    endproperty
    a_mode_decode: assert property (p_mode_decode) else $error("filter mode decode");

    property p_route_rsvd;
        @(posedge clk) disable iff (!rst_n)
        posSel_q[2:1] == 2'b01 |-> analog.posRoute == sdcc_pkg::SDCC_IN_RSVD;
    endproperty
    a_route_rsvd: assert property (p_route_rsvd) else $error("reserved code routed");

    property p_eoc_rise;
        @(posedge clk) disable iff (!rst_n)
        $rose(ctrl1_q[sdcc_pkg::BIT_EOC]) |-> $past(capture) || $past(hit(sdcc_pkg::ADDR_CTRL1));
    endproperty
    a_eoc_rise: assert property (p_eoc_rise) else $error("flag set without cause");
endmodule
`default_nettype wire

//--- rtl/sdcc_pkg.sv
// Package for the converter control block: register map, field layout, constants.
// Assumes a single 100 MHz system clock and an AHB-Lite register port.
package sdcc_pkg;
    // ----------------------------------------
    // Register byte addresses
    // ----------------------------------------
    localparam logic [7:0] ADDR_POS_SEL    = 8'h00;
    localparam logic [7:0] ADDR_DAC_HIGH   = 8'h04;
    localparam logic [7:0] ADDR_DAC_LOW    = 8'h08;
    localparam logic [7:0] ADDR_DAC_CTRL   = 8'h0C;
    localparam logic [7:0] ADDR_RES_LOW    = 8'h10;
    localparam logic [7:0] ADDR_RES_MID    = 8'h14;
    localparam logic [7:0] ADDR_RES_HIGH   = 8'h18;
    localparam logic [7:0] ADDR_CTRL0      = 8'h1C;
    localparam logic [7:0] ADDR_CTRL1      = 8'h20;
    localparam logic [7:0] ADDR_CLK_SEL    = 8'h24;
    // ----------------------------------------
    // Write masks and reset values
    // ----------------------------------------
    localparam logic [7:0] MASK_POS_SEL    = 8'h07;
    localparam logic [7:0] MASK_DAC_LOW    = 8'h0F;
    localparam logic [7:0] MASK_DAC_CTRL   = 8'hE0;
    localparam logic [7:0] MASK_CTRL0      = 8'hFD;
    localparam logic [7:0] MASK_CTRL1      = 8'hFC;
    localparam logic [7:0] MASK_CLK_SEL    = 8'h1F;
    localparam logic [7:0] RST_CTRL0       = 8'h20;
    localparam logic [7:0] RST_ZERO        = 8'h00;
    // ----------------------------------------
    // Bit positions
    // ----------------------------------------
    localparam int BIT_DAC_EN       = 7;
    localparam int BIT_SOFT_RST     = 7;
    localparam int BIT_SLEEP        = 6;
    localparam int BIT_POWER_OFF    = 5;
    localparam int BIT_REF_PAIR     = 0;
    localparam int BIT_NEG_BUF      = 4;
    localparam int BIT_POS_BUF      = 3;
    localparam int BIT_LATCH        = 2;
    localparam int BIT_EOC          = 1;
    localparam logic [4:0] CLK_UNDIVIDED = 5'h1F;
    localparam logic [2:0] OSR_CODE_MAX  = 3'h7;
    localparam int OSR_MAX_LOG2     = 14;
    localparam logic [7:0] DIV_LONG = 8'h1E;
    localparam logic [7:0] DIV_SHORT = 8'h0C;

    // Analog routing targets
    typedef enum logic [2:0] {
        SDCC_IN_PIN0, SDCC_IN_PIN2, SDCC_IN_DACO, SDCC_IN_GND,
        SDCC_IN_CM, SDCC_IN_TSP, SDCC_IN_RSVD
    } sdcc_route_t;
    typedef enum logic [1:0] {
        SDCC_DREF_REG, SDCC_DREF_VIN, SDCC_DREF_CM
    } sdcc_dref_t;

    // Controls toward the analog core
    typedef struct packed {
        sdcc_route_t posRoute;
        logic [11:0] dacCode;
        logic        dacEnable;
        sdcc_dref_t  dacRef;
        logic        powerDown;
        logic        sleep;
        logic        filterReset;
        logic        refExternal;
        logic        negBufEn;
        logic        posBufEn;
        logic        chopDouble;
        logic [7:0]  modDivider;
        logic        filterValid;
        logic [14:0] oversampleRatio;
    } sdcc_analog_t;
endpackage

//--- sim/sdcc_core_model.sv
// Behavioural filter and modulator feeding the converter control block.
// Assumes one start pulse at a time from the bench.
`default_nettype none
module sdcc_core_model (
    input  wire logic                   clk,      // System clock
    input  wire logic                   rst_n,    // Reset, active low
    input  wire sdcc_pkg::sdcc_analog_t analog,   // Controls from block
    input  wire logic                   start,    // Begin a conversion
    input  wire logic                   rogue,    // Deliver while halted
    input  wire logic [23:0]            word,     // Result to deliver
    output logic                        convDone, // Result pulse
    output logic [23:0]                 convData  // Result word
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0]  cnt_q;
    logic [23:0] held_q;
    wire         running = !analog.powerDown && !analog.sleep && !analog.filterReset;
    // Stale word inverted outside the pulse
    assign convData = convDone ? held_q : ~held_q;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            convDone <= 1'b0;
            cnt_q    <= 3'h0;
            held_q   <= 24'h000000;
        end
        else
        begin
            convDone <= 1'b0;
            if (start)
            begin
                cnt_q  <= 3'h4;
                held_q <= word;
            end
            else if (cnt_q != 3'h0)
            begin
                cnt_q <= cnt_q - 3'h1;
            end
            if (cnt_q == 3'h1 && (running || rogue))
            begin
                convDone <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- sim/sdcc_ctrl_tb_top.sv
// Self-checking bench for the converter control block.
// Assumes the design, its package and the core model are compiled first.
`default_nettype none
module sdcc_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LIMIT = 3000;
    logic        clk = 1'b0;
    logic        rst_n, hsel, hwrite, hreadyout, hresp;
    logic        convDone, modClkEn, convIrq, start, rogue;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic [23:0] convData, word;
    int          fails, n_checks, irqs, cyc, n;
    sdcc_pkg::sdcc_analog_t analog;
    logic [7:0]  rA [7] = '{8'h00, 8'h0C, 8'h1C, 8'h20, 8'h24, 8'h08, 8'h28};
    logic [7:0]  rW [7] = '{8'hFF, 8'hFF, 8'hFF, 8'hFD, 8'hFF, 8'hFF, 8'hFF};
    logic [7:0]  rE [7] = '{8'h07, 8'hE0, 8'hFD, 8'hFC, 8'h1F, 8'h0F, 8'h00};
    logic [2:0]  rt [8] = '{sdcc_pkg::SDCC_IN_PIN0, sdcc_pkg::SDCC_IN_PIN2,
        sdcc_pkg::SDCC_IN_RSVD, sdcc_pkg::SDCC_IN_RSVD, sdcc_pkg::SDCC_IN_DACO,
        sdcc_pkg::SDCC_IN_GND, sdcc_pkg::SDCC_IN_CM, sdcc_pkg::SDCC_IN_TSP};
    logic [1:0]  dr [4] = '{sdcc_pkg::SDCC_DREF_REG, sdcc_pkg::SDCC_DREF_VIN,
        sdcc_pkg::SDCC_DREF_CM, sdcc_pkg::SDCC_DREF_CM};
    logic [7:0]  cs [3] = '{8'h00, 8'h02, 8'h1F};
    int          ce [3] = '{2, 6, 1};

    always #5 clk = ~clk;

    sdcc_ctrl dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .convDone(convDone), .convData(convData), .analog(analog),
        .modClkEn(modClkEn), .convIrq(convIrq));

    sdcc_core_model core (.clk(clk), .rst_n(rst_n), .analog(analog), .start(start),
        .rogue(rogue), .word(word), .convDone(convDone), .convData(convData));

    task automatic test_done();
        $display("Checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One single AHB transfer, read data left in rd
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask

    // Write, then let the register update land
    task automatic wrs(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
        @(posedge clk);
    endtask

    task automatic conv(input logic [23:0] w);
        start <= 1'b1;
        word  <= w;
        @(posedge clk);
        start <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    task automatic res(input logic [23:0] e);
        xfer(sdcc_pkg::ADDR_RES_LOW, 1'b0, 0);
        chk(rd, {24'h0, e[7:0]});
        xfer(sdcc_pkg::ADDR_RES_MID, 1'b0, 0);
        chk(rd, {24'h0, e[15:8]});
        xfer(sdcc_pkg::ADDR_RES_HIGH, 1'b0, 0);
        chk(rd, {24'h0, e[23:16]});
    endtask

    task automatic tick(output int t);
        t = 0;
        do @(posedge clk); while (modClkEn !== 1'b1);
        do
        begin
            @(posedge clk);
            t++;
        end
        while (modClkEn !== 1'b1);
    endtask

    always @(posedge clk)
    begin
        if (convIrq === 1'b1) irqs++;
        cyc++;
        if (cyc == LIMIT)
        begin
            fails++;
            test_done();
        end
    end

    initial
    begin
        {rst_n, hsel, hwrite, start, rogue} = 5'h00;
        {haddr, htrans, hwdata, word} = '0;
        hsize = 3'h2;
        fails = 0;
        n_checks = 0;
        irqs = 0;
        cyc = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        chk(analog.powerDown, 1'b1);
        chk({hreadyout, hresp}, 2'b10);
        for (int i = 0; i < 7; i++)
        begin
            xfer(rA[i], 1'b0, 0);
            chk(rd, rA[i] == sdcc_pkg::ADDR_CTRL0 ? 32'h20 : 32'h0);
        end
        for (int i = 0; i < 7; i++)
        begin
            xfer(rA[i], 1'b1, rW[i]);
            xfer(rA[i], 1'b0, 0);
            chk(rd, rE[i]);
        end
        for (int k = 0; k < 8; k++)
        begin
            wrs(sdcc_pkg::ADDR_POS_SEL, k);
            chk(analog.posRoute, rt[k]);
            wrs(sdcc_pkg::ADDR_CTRL0, 32'h20 | (k << 2));
            chk(analog.oversampleRatio, 32'd16384 >> k);
            wrs(sdcc_pkg::ADDR_CTRL1, k << 5);
            chk(analog.filterValid, !k[0]);
            if (!k[0]) chk(analog.chopDouble, k < 4);
            if (!k[0]) chk(analog.modDivider, k[1] ? 8'h0C : 8'h1E);
        end
        for (int k = 0; k < 4; k++)
        begin
            wrs(sdcc_pkg::ADDR_DAC_CTRL, (k << 5) | (k[0] << 7));
            chk(analog.dacRef, dr[k]);
            chk(analog.dacEnable, k[0]);
        end
        wrs(sdcc_pkg::ADDR_CTRL1, 8'h10);
        chk({analog.negBufEn, analog.posBufEn}, 2'b10);
        wrs(sdcc_pkg::ADDR_CTRL1, 8'h08);
        chk({analog.negBufEn, analog.posBufEn}, 2'b01);
        wrs(sdcc_pkg::ADDR_CTRL0, 8'h21);
        chk(analog.refExternal, 1'b1);
        wrs(sdcc_pkg::ADDR_DAC_HIGH, 8'hAB);
        wrs(sdcc_pkg::ADDR_DAC_LOW, 8'h05);
        chk(analog.dacCode, 12'hABF);
        xfer(sdcc_pkg::ADDR_DAC_LOW, 1'b0, 0);
        chk(rd, 8'h05);
        wrs(sdcc_pkg::ADDR_DAC_HIGH, 8'hCD);
        chk(analog.dacCode, 12'hCD5);
        for (int k = 0; k < 3; k++)
        begin
            wrs(sdcc_pkg::ADDR_CLK_SEL, cs[k]);
            tick(n);
            tick(n);
            chk(n, ce[k]);
        end
        // Core forced to deliver while the converter is halted
        rogue <= 1'b1;
        conv(24'h777777);
        wrs(sdcc_pkg::ADDR_CTRL0, 8'h80);
        chk(analog.filterReset, 1'b1);
        conv(24'h777777);
        wrs(sdcc_pkg::ADDR_CTRL0, 8'h40);
        chk(analog.sleep, 1'b1);
        conv(24'h777777);
        xfer(sdcc_pkg::ADDR_CTRL1, 1'b0, 0);
        chk(rd, 8'h08);
        chk(irqs, 0);
        rogue <= 1'b0;
        wrs(sdcc_pkg::ADDR_CTRL0, 8'h00);
        conv(24'h123456);
        res(24'h123456);
        conv(24'hABCDEF);
        xfer(sdcc_pkg::ADDR_RES_LOW, 1'b1, 8'hFF);
        res(24'hABCDEF);
        xfer(sdcc_pkg::ADDR_CTRL1, 1'b0, 0);
        chk(rd, 8'h0A);
        chk(irqs, 2);
        wrs(sdcc_pkg::ADDR_CTRL1, 8'h0C);
        conv(24'h111111);
        res(24'hABCDEF);
        xfer(sdcc_pkg::ADDR_CTRL1, 1'b0, 0);
        chk(rd, 8'h0C);
        chk(irqs, 2);
        wrs(sdcc_pkg::ADDR_CTRL1, 8'h08);
        conv(24'h654321);
        res(24'h654321);
        wrs(sdcc_pkg::ADDR_CTRL0, 8'h20);
        chk(analog.powerDown, 1'b1);
        test_done();
    end
endmodule
`default_nettype wire
